// *** rtl/pl_power_limit_regs.svh ***
// address map, field positions, reset values and timing counts of the power limit bank
`ifndef PL_POWER_LIMIT_REGS_SVH
`define PL_POWER_LIMIT_REGS_SVH

// register address: {domain[1:0], offset[2:0]}
`define PL_DOM_PKG        2'h0
`define PL_DOM_CORE       2'h1
`define PL_DOM_UNCORE     2'h2
`define PL_DOM_MISC       2'h3
`define PL_OFF_LIMIT      3'h0
`define PL_OFF_ENERGY     3'h1
`define PL_OFF_POLICY     3'h2
`define PL_OFF_PERF       3'h3
`define PL_OFF_INFO       3'h4
`define PL_OFF_UNIT       3'h0

// package limit control fields
`define PL_PKG_LIM1_MSB   14
`define PL_PKG_EN1_BIT    15
`define PL_PKG_CLAMP1_BIT 16
`define PL_PKG_Y1_LSB     17
`define PL_PKG_Y1_MSB     21
`define PL_PKG_Z1_LSB     22
`define PL_PKG_Z1_MSB     23
`define PL_PKG_LIM2_LSB   32
`define PL_PKG_LIM2_MSB   46
`define PL_PKG_EN2_BIT    47
`define PL_PKG_CLAMP2_BIT 48
`define PL_PKG_W2_LSB     49
`define PL_PKG_W2_MSB     55
`define PL_PKG_Y2_MSB     53
`define PL_PKG_Z2_LSB     54
`define PL_PKG_LOCK_BIT   63
`define PL_PKG_WMASK      64'h80FF_FFFF_00FF_FFFF
`define PL_PKG_W2_FIELD   64'h00FE_0000_0000_0000
`define PL_PKG_RST        64'h0000_0000_0000_0000

// plane limit control fields (same low layout as package limit one)
`define PL_PLANE_LOCK_BIT 31
`define PL_PLANE_WMASK    32'h80FF_FFFF
`define PL_PLANE_RST      32'h0000_0000
`define PL_PRIO_MSB       4
`define PL_CORE_PRIO_RST  5'h00
`define PL_UNCORE_PRIO_RST 5'h10

// power range fields
`define PL_INFO_MIN_LSB   16
`define PL_INFO_MAX_LSB   32
`define PL_INFO_WIN_LSB   48

// scaling unit fields
`define PL_UNIT_ESU_LSB   8
`define PL_UNIT_TU_LSB    16

// energy refresh period
`define PL_REFRESH_US     1000
`define PL_CLK_MHZ        200
`define PL_REFRESH_CYC    (`PL_REFRESH_US * `PL_CLK_MHZ)

`endif

// *** rtl/pl_pkg.sv ***
// types of the power limit register bank
package pl_pkg;
  typedef logic [4:0]  pl_addr_t;
  typedef logic [63:0] pl_word_t;
  typedef logic [31:0] pl_cnt_t;

  typedef struct packed {
    pl_word_t    pkg_limit;
    logic [31:0] core_limit;
    logic [31:0] uncore_limit;
    logic [4:0]  core_prio;
    logic [4:0]  uncore_prio;
    pl_cnt_t     pkg_energy;
    pl_cnt_t     core_energy;
    pl_cnt_t     uncore_energy;
    pl_cnt_t     pkg_acc;
    pl_cnt_t     core_acc;
    pl_cnt_t     uncore_acc;
    pl_cnt_t     pkg_thr;
    pl_cnt_t     core_thr;
    pl_cnt_t     refresh_cnt;
    pl_word_t    rdata;
    logic        rvalid;
  } pl_state_s;
endpackage

// *** rtl/pl_power_limit_regs.sv ***
// running-average power limiting register bank, reached as model-specific registers
`timescale 1ns/1ps
`default_nettype none
`include "pl_power_limit_regs.svh"

// Behaviour
// - package limit bits 14:0 hold limit one, bit 15 enables it
// - package bit 16 lets cores drop below requested state for limit one
// - window one bits 23:17: 2^Y*(1+Z/4) time units, Y 21:17, Z 23:22
// - package limit bits 46:32 hold limit two, bit 47 enables it
// - package bit 48 is clamp two, independent of clamp one
// - window two bits 55:49, exponent 53:49, fraction 55:54, same formula
// - window two may be hard-wired; writes dropped, reads give fixed value
// - package lock bit 63 freezes the package limit register until reset
// - read-only package energy counter, 32 bits, refreshed every millisecond, wraps
// - power range: thermal 14:0, minimum 30:16, maximum 46:32 in power units
// - power range bits 53:48 report the largest programmable window
// - read-only package throttle counter accumulates throttled time in time units
// - plane limit: limit 14:0, enable 15, clamp 16, both planes alike
// - plane window 23:17 decodes as 2^Y times 1.Z, Y 21:17, Z 23:22
// - plane lock bit 31 freezes that plane's limit and priority until reset
// - read-only plane energy counters refreshed every millisecond
// - plane priority bits 4:0 feed the budget controller, 31 highest
// - priority reset values favour the uncore graphics plane
// - server platforms only: read-only core plane throttle counter
// - read-only scaling unit register: power 3:0, energy 12:8, time 19:16
module pl_power_limit_regs #(
  parameter int unsigned REFRESH_CYC  = `PL_REFRESH_CYC,
  parameter bit          SERVER       = 1'b0,
  parameter bit          WIN2_FIXED   = 1'b0,
  parameter logic [6:0]  WIN2_VALUE   = 7'h00,
  parameter logic [3:0]  POWER_UNIT   = 4'h3,
  parameter logic [4:0]  ENERGY_UNIT  = 5'h10,
  parameter logic [3:0]  TIME_UNIT    = 4'hA,
  parameter logic [14:0] TDP_POWER    = 15'h0000,
  parameter logic [14:0] MIN_POWER    = 15'h0000,
  parameter logic [14:0] MAX_POWER    = 15'h0000,
  parameter logic [5:0]  MAX_WINDOW   = 6'h00
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             msr_rd,
  input  wire logic             msr_wr,
  input  wire pl_pkg::pl_addr_t msr_addr,
  input  wire pl_pkg::pl_word_t msr_wdata,
  output logic                  msr_rvalid,
  output pl_pkg::pl_word_t      msr_rdata,
  input  wire logic [15:0]      pkg_energy_delta,
  input  wire logic [15:0]      core_energy_delta,
  input  wire logic [15:0]      uncore_energy_delta,
  input  wire logic             time_unit_tick,
  input  wire logic             pkg_throttled,
  input  wire logic             core_throttled,
  output logic [14:0]           pkg_limit1,
  output logic                  pkg_enable1,
  output logic                  pkg_clamp1,
  output logic [4:0]            pkg_win1_exp,
  output logic [1:0]            pkg_win1_frac,
  output logic [14:0]           pkg_limit2,
  output logic                  pkg_enable2,
  output logic                  pkg_clamp2,
  output logic [4:0]            pkg_win2_exp,
  output logic [1:0]            pkg_win2_frac,
  output logic                  pkg_locked,
  output logic [14:0]           core_limit,
  output logic                  core_enable,
  output logic                  core_clamp,
  output logic [4:0]            core_win_exp,
  output logic [1:0]            core_win_frac,
  output logic                  core_locked,
  output logic [4:0]            core_priority,
  output logic [14:0]           uncore_limit,
  output logic                  uncore_enable,
  output logic                  uncore_clamp,
  output logic [4:0]            uncore_win_exp,
  output logic [1:0]            uncore_win_frac,
  output logic                  uncore_locked,
  output logic [4:0]            uncore_priority
);
  import pl_pkg::*;

  pl_state_s st_reg;
  pl_state_s st_next;
  logic      refresh_tick;
  pl_word_t  unit_word;
  pl_word_t  info_word;
  pl_word_t  rd_word;
  pl_word_t  pkg_wval;

  localparam pl_cnt_t REFRESH_LAST = pl_cnt_t'(REFRESH_CYC - 1);

  // one period shared by all meters, so software sees the three counters move together
  assign refresh_tick = (st_reg.refresh_cnt == REFRESH_LAST);

  assign unit_word = {44'h000_0000_0000, TIME_UNIT, 3'h0, ENERGY_UNIT, 4'h0, POWER_UNIT};
  assign info_word = {10'h000, MAX_WINDOW, 1'b0, MAX_POWER, 1'b0, MIN_POWER, 1'b0, TDP_POWER};

  // write value of the package limit with reserved bits cleared and window two pinned if fixed
  always_comb begin
    pkg_wval = msr_wdata & `PL_PKG_WMASK;
    if (WIN2_FIXED) begin
      pkg_wval[`PL_PKG_W2_MSB:`PL_PKG_W2_LSB] = WIN2_VALUE;
    end
  end

  // read mux; unmapped and absent registers read as zero
  always_comb begin
    rd_word = 64'h0000_0000_0000_0000;
    unique case (msr_addr[4:3])
      `PL_DOM_PKG: begin
        unique case (msr_addr[2:0])
          `PL_OFF_LIMIT:  rd_word = st_reg.pkg_limit;
          `PL_OFF_ENERGY: rd_word = {32'h0000_0000, st_reg.pkg_energy};
          `PL_OFF_PERF:   rd_word = {32'h0000_0000, st_reg.pkg_thr};
          `PL_OFF_INFO:   rd_word = info_word;
          default:        rd_word = 64'h0000_0000_0000_0000;
        endcase
      end
      `PL_DOM_CORE: begin
        unique case (msr_addr[2:0])
          `PL_OFF_LIMIT:  rd_word = {32'h0000_0000, st_reg.core_limit};
          `PL_OFF_ENERGY: rd_word = {32'h0000_0000, st_reg.core_energy};
          `PL_OFF_POLICY: rd_word = 64'(st_reg.core_prio);
          `PL_OFF_PERF:   rd_word = SERVER ? {32'h0000_0000, st_reg.core_thr} : 64'h0000_0000_0000_0000;
          default:        rd_word = 64'h0000_0000_0000_0000;
        endcase
      end
      `PL_DOM_UNCORE: begin
        // the uncore plane does not exist on server platforms
        if (!SERVER) begin
          unique case (msr_addr[2:0])
            `PL_OFF_LIMIT:  rd_word = {32'h0000_0000, st_reg.uncore_limit};
            `PL_OFF_ENERGY: rd_word = {32'h0000_0000, st_reg.uncore_energy};
            `PL_OFF_POLICY: rd_word = 64'(st_reg.uncore_prio);
            default:        rd_word = 64'h0000_0000_0000_0000;
          endcase
        end
      end
      `PL_DOM_MISC: begin
        if (msr_addr[2:0] == `PL_OFF_UNIT) begin
          rd_word = unit_word;
        end
      end
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rvalid = msr_rd;
    if (msr_rd) begin
      st_next.rdata = rd_word;
    end

    if (msr_wr) begin
      if ((msr_addr == {`PL_DOM_PKG, `PL_OFF_LIMIT}) && !st_reg.pkg_limit[`PL_PKG_LOCK_BIT]) begin
        st_next.pkg_limit = pkg_wval;
      end
      if (!st_reg.core_limit[`PL_PLANE_LOCK_BIT]) begin
        if (msr_addr == {`PL_DOM_CORE, `PL_OFF_LIMIT}) begin
          st_next.core_limit = msr_wdata[31:0] & `PL_PLANE_WMASK;
        end
        if (msr_addr == {`PL_DOM_CORE, `PL_OFF_POLICY}) begin
          st_next.core_prio = msr_wdata[`PL_PRIO_MSB:0];
        end
      end
      if (!SERVER && !st_reg.uncore_limit[`PL_PLANE_LOCK_BIT]) begin
        if (msr_addr == {`PL_DOM_UNCORE, `PL_OFF_LIMIT}) begin
          st_next.uncore_limit = msr_wdata[31:0] & `PL_PLANE_WMASK;
        end
        if (msr_addr == {`PL_DOM_UNCORE, `PL_OFF_POLICY}) begin
          st_next.uncore_prio = msr_wdata[`PL_PRIO_MSB:0];
        end
      end
    end

    // meter deltas gather every cycle and are published once per refresh period
    st_next.refresh_cnt = refresh_tick ? 32'h0000_0000 : st_reg.refresh_cnt + 32'h0000_0001;
    if (refresh_tick) begin
      st_next.pkg_energy    = st_reg.pkg_energy + st_reg.pkg_acc;
      st_next.core_energy   = st_reg.core_energy + st_reg.core_acc;
      st_next.uncore_energy = st_reg.uncore_energy + st_reg.uncore_acc;
      // the delta of the publishing cycle starts the next period so none is lost
      st_next.pkg_acc    = {16'h0000, pkg_energy_delta};
      st_next.core_acc   = {16'h0000, core_energy_delta};
      st_next.uncore_acc = SERVER ? 32'h0000_0000 : {16'h0000, uncore_energy_delta};
    end else begin
      st_next.pkg_acc    = st_reg.pkg_acc + {16'h0000, pkg_energy_delta};
      st_next.core_acc   = st_reg.core_acc + {16'h0000, core_energy_delta};
      st_next.uncore_acc = SERVER ? 32'h0000_0000 : st_reg.uncore_acc + {16'h0000, uncore_energy_delta};
    end

    if (time_unit_tick && pkg_throttled) begin
      st_next.pkg_thr = st_reg.pkg_thr + 32'h0000_0001;
    end
    if (SERVER && time_unit_tick && core_throttled) begin
      st_next.core_thr = st_reg.core_thr + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_reg              <= '0;
      st_reg.pkg_limit    <= `PL_PKG_RST;
      st_reg.core_limit   <= `PL_PLANE_RST;
      st_reg.uncore_limit <= `PL_PLANE_RST;
      st_reg.core_prio    <= `PL_CORE_PRIO_RST;
      st_reg.uncore_prio  <= `PL_UNCORE_PRIO_RST;
      if (WIN2_FIXED) begin
        st_reg.pkg_limit[`PL_PKG_W2_MSB:`PL_PKG_W2_LSB] <= WIN2_VALUE;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  assign msr_rvalid = st_reg.rvalid;
  assign msr_rdata  = st_reg.rdata;

  // window fields leave raw; the limiter decodes them as 2^Y*(4+Z)/4 time units
  assign pkg_limit1    = st_reg.pkg_limit[`PL_PKG_LIM1_MSB:0];
  assign pkg_enable1   = st_reg.pkg_limit[`PL_PKG_EN1_BIT];
  assign pkg_clamp1    = st_reg.pkg_limit[`PL_PKG_CLAMP1_BIT];
  assign pkg_win1_exp  = st_reg.pkg_limit[`PL_PKG_Y1_MSB:`PL_PKG_Y1_LSB];
  assign pkg_win1_frac = st_reg.pkg_limit[`PL_PKG_Z1_MSB:`PL_PKG_Z1_LSB];
  assign pkg_limit2    = st_reg.pkg_limit[`PL_PKG_LIM2_MSB:`PL_PKG_LIM2_LSB];
  assign pkg_enable2   = st_reg.pkg_limit[`PL_PKG_EN2_BIT];
  assign pkg_clamp2    = st_reg.pkg_limit[`PL_PKG_CLAMP2_BIT];
  assign pkg_win2_exp  = st_reg.pkg_limit[`PL_PKG_Y2_MSB:`PL_PKG_W2_LSB];
  assign pkg_win2_frac = st_reg.pkg_limit[`PL_PKG_W2_MSB:`PL_PKG_Z2_LSB];
  assign pkg_locked    = st_reg.pkg_limit[`PL_PKG_LOCK_BIT];

  assign core_limit      = st_reg.core_limit[`PL_PKG_LIM1_MSB:0];
  assign core_enable     = st_reg.core_limit[`PL_PKG_EN1_BIT];
  assign core_clamp      = st_reg.core_limit[`PL_PKG_CLAMP1_BIT];
  assign core_win_exp    = st_reg.core_limit[`PL_PKG_Y1_MSB:`PL_PKG_Y1_LSB];
  assign core_win_frac   = st_reg.core_limit[`PL_PKG_Z1_MSB:`PL_PKG_Z1_LSB];
  assign core_locked     = st_reg.core_limit[`PL_PLANE_LOCK_BIT];
  assign core_priority   = st_reg.core_prio;
  assign uncore_limit    = st_reg.uncore_limit[`PL_PKG_LIM1_MSB:0];
  assign uncore_enable   = st_reg.uncore_limit[`PL_PKG_EN1_BIT];
  assign uncore_clamp    = st_reg.uncore_limit[`PL_PKG_CLAMP1_BIT];
  assign uncore_win_exp  = st_reg.uncore_limit[`PL_PKG_Y1_MSB:`PL_PKG_Y1_LSB];
  assign uncore_win_frac = st_reg.uncore_limit[`PL_PKG_Z1_MSB:`PL_PKG_Z1_LSB];
  assign uncore_locked   = st_reg.uncore_limit[`PL_PLANE_LOCK_BIT];
  assign uncore_priority = st_reg.uncore_prio;

  // checks rest while reset is held; past values across the release are reset values
  a_pkg_lock_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    pkg_locked |=> pkg_locked && $stable(st_reg.pkg_limit))
    else $error("locked package limit changed");

  a_core_lock_prio: assert property (@(posedge sys_clk) disable iff (!nrst)
    core_locked |=> $stable(core_priority) && $stable(st_reg.core_limit))
    else $error("locked core plane changed");

  a_win2_pinned: assert property (@(posedge sys_clk) disable iff (!nrst)
    WIN2_FIXED |-> {pkg_win2_frac, pkg_win2_exp} == WIN2_VALUE)
    else $error("fixed window two altered");

  a_pkg_write_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_wr && !pkg_locked && msr_addr == {`PL_DOM_PKG, `PL_OFF_LIMIT}
    |=> (st_reg.pkg_limit & ~`PL_PKG_W2_FIELD) == ($past(msr_wdata) & `PL_PKG_WMASK & ~`PL_PKG_W2_FIELD)
      && (WIN2_FIXED
          || st_reg.pkg_limit[`PL_PKG_W2_MSB:`PL_PKG_W2_LSB] == $past(msr_wdata[`PL_PKG_W2_MSB:`PL_PKG_W2_LSB])))
    else $error("package limit write not taken");

  a_energy_publish: assert property (@(posedge sys_clk) disable iff (!nrst)
    refresh_tick |=> st_reg.pkg_energy == $past(st_reg.pkg_energy) + $past(st_reg.pkg_acc))
    else $error("package energy not published");

  a_energy_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    !refresh_tick |=> $stable(st_reg.core_energy))
    else $error("core energy moved between refreshes");

  a_thr_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    time_unit_tick && pkg_throttled |=> st_reg.pkg_thr == $past(st_reg.pkg_thr) + 32'h0000_0001)
    else $error("package throttle count missed");

  a_unit_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_rd && msr_addr == {`PL_DOM_MISC, `PL_OFF_UNIT} |=> msr_rvalid && msr_rdata == unit_word)
    else $error("unit register read wrong");

  a_prio_favour: assert property (@(posedge sys_clk)
    $rose(nrst) |-> uncore_priority > core_priority)
    else $error("reset priorities do not favour uncore");

  a_uncore_lock_prio: assert property (@(posedge sys_clk) disable iff (!nrst)
    uncore_locked |=> $stable(uncore_priority) && $stable(st_reg.uncore_limit))
    else $error("locked uncore plane changed");

  a_core_energy_publish: assert property (@(posedge sys_clk) disable iff (!nrst)
    refresh_tick |=> st_reg.core_energy == $past(st_reg.core_energy) + $past(st_reg.core_acc))
    else $error("core energy not published");

  a_uncore_energy_publish: assert property (@(posedge sys_clk) disable iff (!nrst)
    refresh_tick |=> st_reg.uncore_energy == $past(st_reg.uncore_energy) + $past(st_reg.uncore_acc))
    else $error("uncore energy not published");

  a_pkg_energy_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
    !refresh_tick |=> $stable(st_reg.pkg_energy) && $stable(st_reg.uncore_energy))
    else $error("energy moved between refreshes");

  a_thr_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !(time_unit_tick && pkg_throttled) |=> $stable(st_reg.pkg_thr))
    else $error("package throttle count moved");

  a_core_thr_count: assert property (@(posedge sys_clk) disable iff (!nrst)
    time_unit_tick && core_throttled
    |=> st_reg.core_thr == $past(st_reg.core_thr) + (SERVER ? 32'h0000_0001 : 32'h0000_0000))
    else $error("core throttle count wrong");

  a_info_read: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_rd && msr_addr == {`PL_DOM_PKG, `PL_OFF_INFO} |=> msr_rvalid && msr_rdata == info_word)
    else $error("power range read wrong");

  a_info_window: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_rd && msr_addr == {`PL_DOM_PKG, `PL_OFF_INFO}
    |=> msr_rdata[`PL_INFO_WIN_LSB+5:`PL_INFO_WIN_LSB] == MAX_WINDOW)
    else $error("largest window read wrong");

  a_core_write_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_wr && !core_locked && msr_addr == {`PL_DOM_CORE, `PL_OFF_LIMIT}
    |=> st_reg.core_limit == ($past(msr_wdata[31:0]) & `PL_PLANE_WMASK))
    else $error("core limit write not taken");

  a_uncore_write_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    !SERVER && msr_wr && !uncore_locked && msr_addr == {`PL_DOM_UNCORE, `PL_OFF_LIMIT}
    |=> st_reg.uncore_limit == ($past(msr_wdata[31:0]) & `PL_PLANE_WMASK))
    else $error("uncore limit write not taken");

  a_core_prio_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_wr && !core_locked && msr_addr == {`PL_DOM_CORE, `PL_OFF_POLICY}
    |=> core_priority == $past(msr_wdata[`PL_PRIO_MSB:0]))
    else $error("core priority write not taken");

  a_prio_write_take: assert property (@(posedge sys_clk) disable iff (!nrst)
    !SERVER && msr_wr && !uncore_locked && msr_addr == {`PL_DOM_UNCORE, `PL_OFF_POLICY}
    |=> uncore_priority == $past(msr_wdata[`PL_PRIO_MSB:0]))
    else $error("uncore priority write not taken");

  a_pkg_lock_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_wr && !pkg_locked && msr_addr == {`PL_DOM_PKG, `PL_OFF_LIMIT} && msr_wdata[`PL_PKG_LOCK_BIT]
    |=> pkg_locked)
    else $error("package lock not taken");

  a_clamp_split: assert property (@(posedge sys_clk) disable iff (!nrst)
    msr_wr && !pkg_locked && msr_addr == {`PL_DOM_PKG, `PL_OFF_LIMIT}
    && msr_wdata[`PL_PKG_CLAMP2_BIT] && !msr_wdata[`PL_PKG_CLAMP1_BIT]
    |=> pkg_clamp2 && !pkg_clamp1)
    else $error("clamp two not independent");

  a_refresh_range: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_reg.refresh_cnt <= REFRESH_LAST)
    else $error("refresh counter out of range");
endmodule

`default_nettype wire

// *** verification/pl_testbench.sv ***
// self-checking bench for the power limit register bank
`timescale 1ns/1ps
`default_nettype none
`include "pl_power_limit_regs.svh"
module testbench;
  import pl_pkg::*;
  localparam logic [3:0]  PU   = 4'h3;
  localparam logic [4:0]  ESU  = 5'h10;
  localparam logic [3:0]  TU   = 4'hA;
  localparam logic [14:0] TDP  = 15'h01F4;
  localparam logic [14:0] MINP = 15'h0064;
  localparam logic [14:0] MAXP = 15'h03E8;
  localparam logic [5:0]  MAXW = 6'h2A;
  localparam logic [6:0]  W2V  = 7'h5B;
  localparam pl_word_t    W2_W = pl_word_t'(W2V) << `PL_PKG_W2_LSB;
  localparam pl_word_t    UNIT_W = {44'h0, TU, 3'h0, ESU, 4'h0, PU};
  localparam pl_word_t    INFO_W = {10'h0, MAXW, 1'b0, MAXP, 1'b0, MINP, 1'b0, TDP};
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        msr_rd = 1'b0;
  logic        msr_wr = 1'b0;
  pl_addr_t    msr_addr = 5'h00;
  pl_word_t    msr_wdata = 64'h0000_0000_0000_0000;
  logic        msr_rvalid;
  pl_word_t    msr_rdata;
  logic [15:0] pkg_energy_delta = 16'h0000;
  logic [15:0] core_energy_delta = 16'h0000;
  logic [15:0] uncore_energy_delta = 16'h0000;
  logic        time_unit_tick = 1'b0;
  logic        pkg_throttled = 1'b0;
  logic        core_throttled = 1'b0;
  logic [14:0] pkg_limit1, pkg_limit2, core_limit, uncore_limit;
  logic        pkg_enable1, pkg_clamp1, pkg_enable2, pkg_clamp2, pkg_locked;
  logic [4:0]  pkg_win1_exp, pkg_win2_exp, core_win_exp, uncore_win_exp, core_priority, uncore_priority;
  logic [1:0]  pkg_win1_frac, pkg_win2_frac, core_win_frac, uncore_win_frac;
  logic        core_enable, core_clamp, core_locked, uncore_enable, uncore_clamp, uncore_locked;
  int          err_total = 0;
  int          compares = 0;
  pl_word_t    exp_q[$];

  pl_power_limit_regs #(.REFRESH_CYC(8), .SERVER(1'b0), .POWER_UNIT(PU), .ENERGY_UNIT(ESU), .TIME_UNIT(TU),
    .WIN2_FIXED(1'b1), .WIN2_VALUE(W2V),
    .TDP_POWER(TDP), .MIN_POWER(MINP), .MAX_POWER(MAXP), .MAX_WINDOW(MAXW)) pl_power_limit_regs_inst (
    .sys_clk, .nrst, .msr_rd, .msr_wr, .msr_addr, .msr_wdata, .msr_rvalid, .msr_rdata,
    .pkg_energy_delta, .core_energy_delta, .uncore_energy_delta, .time_unit_tick, .pkg_throttled,
    .core_throttled, .pkg_limit1, .pkg_enable1, .pkg_clamp1, .pkg_win1_exp, .pkg_win1_frac, .pkg_limit2,
    .pkg_enable2, .pkg_clamp2, .pkg_win2_exp, .pkg_win2_frac, .pkg_locked, .core_limit, .core_enable,
    .core_clamp, .core_win_exp, .core_win_frac, .core_locked, .core_priority, .uncore_limit, .uncore_enable,
    .uncore_clamp, .uncore_win_exp, .uncore_win_frac, .uncore_locked, .uncore_priority);

  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input pl_addr_t a, input pl_word_t d);
    @(posedge sys_clk);
    msr_wr <= 1'b1;
    msr_addr <= a;
    msr_wdata <= d;
    @(posedge sys_clk);
    msr_wr <= 1'b0;
  endtask

  // the note goes in before the strobe, so the watcher always finds it
  task automatic rd(input pl_addr_t a, input pl_word_t e);
    @(posedge sys_clk);
    exp_q.push_back(e);
    msr_rd <= 1'b1;
    msr_addr <= a;
    @(posedge sys_clk);
    msr_rd <= 1'b0;
  endtask

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // answers arrive in request order, so the oldest note matches
  always @(posedge sys_clk) begin
    if (msr_rvalid === 1'b1) begin
      if (exp_q.size() > 0) chk(msr_rdata, exp_q.pop_front());
      else chk(64'h1, 64'h0);
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    close_out();
  end

  initial begin
    pl_addr_t    ra [0:8] = '{5'h00, 5'h08, 5'h10, 5'h0A, 5'h12, 5'h18, 5'h04, 5'h02, 5'h1F};
    pl_word_t    re [0:8] = '{W2_W, 64'h0, 64'h0, 64'h0, 64'h10, UNIT_W, INFO_W, 64'h0, 64'h0};
    pl_word_t    pv [0:2];
    pl_word_t    d;
    pl_word_t    e;
    logic [15:0] cd;
    logic [15:0] ud;
    pl_addr_t    lim_a;
    pl_addr_t    pol_a;
    void'($urandom(98465));
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
    settle();
    chk({core_priority, uncore_priority}, {5'h00, 5'h10});
    wr(5'h01, 64'hFFFF_FFFF_FFFF_FFFF);
    wr(5'h18, 64'h0000_0000_0000_0000);
    rd(5'h18, UNIT_W);
    // energy: one burst of eight deltas, then idle for whole refresh periods
    cd = 16'($urandom);
    ud = 16'($urandom);
    @(posedge sys_clk);
    pkg_energy_delta <= 16'hFFFF;
    core_energy_delta <= cd;
    uncore_energy_delta <= ud;
    repeat (8) @(posedge sys_clk);
    pkg_energy_delta <= 16'h0000;
    core_energy_delta <= 16'h0000;
    uncore_energy_delta <= 16'h0000;
    repeat (24) @(posedge sys_clk);
    rd(5'h01, 64'h0007_FFF8);
    rd(5'h09, {32'h0, 32'(cd) * 32'd8});
    rd(5'h11, {32'h0, 32'(ud) * 32'd8});
    // throttled time counts only ticks seen while throttled
    @(posedge sys_clk);
    pkg_throttled <= 1'b1;
    core_throttled <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      time_unit_tick <= 1'b1;
      @(posedge sys_clk);
      time_unit_tick <= 1'b0;
      if (i == 4) pkg_throttled <= 1'b0;
    end
    rd(5'h03, 64'h5);
    rd(5'h0B, 64'h0);
    // package limit: random, clamp two alone, every writable bit but the lock
    pv[0] = {1'b0, 31'($urandom), 32'($urandom)};
    pv[1] = 64'h0001_0000_0000_0000;
    pv[2] = 64'h7FFF_FFFF_FFFF_FFFF;
    for (int i = 0; i < 3; i++) begin
      e = (pv[i] & `PL_PKG_WMASK & ~`PL_PKG_W2_FIELD) | W2_W;
      wr(5'h00, pv[i]);
      rd(5'h00, e);
      settle();
      chk({pkg_locked, 7'h0, pkg_win2_frac, pkg_win2_exp, pkg_clamp2, pkg_enable2, pkg_limit2, 8'h0,
           pkg_win1_frac, pkg_win1_exp, pkg_clamp1, pkg_enable1, pkg_limit1}, e);
    end
    d = {1'b1, 31'($urandom), 32'($urandom)};
    e = (d & `PL_PKG_WMASK & ~`PL_PKG_W2_FIELD) | W2_W;
    wr(5'h00, d);
    wr(5'h00, ~d);
    rd(5'h00, e);
    settle();
    chk({pkg_locked, pkg_limit1, pkg_limit2}, {1'b1, e[14:0], e[46:32]});
    // planes: core first, so uncore writes land while core is locked
    for (int p = 0; p < 2; p++) begin
      lim_a = (p == 0) ? 5'h08 : 5'h10;
      pol_a = (p == 0) ? 5'h0A : 5'h12;
      d = {32'h0, 1'b0, 31'($urandom)};
      e = d & {32'h0, `PL_PLANE_WMASK};
      wr(lim_a, d);
      wr(pol_a, {32'h0, 32'($urandom) | 32'h1F});
      rd(lim_a, e);
      rd(pol_a, 64'h1F);
      settle();
      chk((p == 0) ? {core_locked, 7'h0, core_win_frac, core_win_exp, core_clamp, core_enable, core_limit}
                   : {uncore_locked, 7'h0, uncore_win_frac, uncore_win_exp, uncore_clamp, uncore_enable,
                      uncore_limit}, e[31:0]);
      chk((p == 0) ? core_priority : uncore_priority, 5'h1F);
      wr(lim_a, e | 64'h8000_0000);
      wr(lim_a, 64'h0000_0000);
      wr(pol_a, 64'h0000_0003);
      rd(lim_a, e | 64'h8000_0000);
      rd(pol_a, 64'h1F);
    end
    // a fresh reset lifts the package lock
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(5'h00, W2_W);
    wr(5'h00, 64'h0000_0000_0000_8001);
    rd(5'h00, 64'h0000_0000_0000_8001 | W2_W);
    rd(5'h01, 64'h0);
    settle();
    chk(exp_q.size(), 64'h0);
    close_out();
  end
endmodule
`default_nettype wire
